// ### bpvcr_consts.svh
// Offsets, field positions and reset values for the rail configuration slice.
// Included by the package and by the top design module; holds definitions only.
`ifndef BPVCR_CONSTS_SVH
`define BPVCR_CONSTS_SVH

`define BPVCR_OFF_D_MODE    8'hD2
`define BPVCR_OFF_PHASE     8'hD3
`define BPVCR_OFF_A_LIMIT   8'hD5
`define BPVCR_OFF_B_LIMIT   8'hD6
`define BPVCR_OFF_A_FIRST   8'hD7
`define BPVCR_OFF_A_SECOND  8'hD8
`define BPVCR_BIT_SHED_B    4
`define BPVCR_BIT_SHED_A    3
`define BPVCR_BIT_PH_B      2
`define BPVCR_BIT_AUTO      7
`define BPVCR_RST_PHASE     8'h00
`define BPVCR_RST_TARGET    8'h00
`define BPVCR_RST_MODE      2'h0
`define BPVCR_MODE_PWM      2'h2
`define BPVCR_PH_MAX_DUAL   2'h1

`endif

// ### bpvcr_pkg.sv
// Types shared by the rail configuration slice.
// Assumes the constants header is on the include path.
`default_nettype none
`include "bpvcr_consts.svh"

package bpvcr_pkg;
  typedef enum logic [1:0] {
    BPVCR_RUN_PWM,
    BPVCR_RUN_AUTO
  } bpvcr_run_t;
  typedef logic [6:0] bpvcr_vcode_t;
endpackage

`default_nettype wire

// ### bpvcr_reg8.sv
// One 8-bit writable register with a per-bit write mask and clock enable.
// Assumes a synchronous write strobe in the CLK domain.
`timescale 1ns/1ps
`default_nettype none

module bpvcr_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RESET_VAL;
    end else if (ce && we) begin
      q <= (wdata & WMASK) | (q & ~WMASK);
    end
  end
endmodule

`default_nettype wire

// ### bpvcr_top.sv
// Configuration registers for phase count, shedding, voltage ceilings and
// the first rail's two target settings, plus the resulting control outputs.
// Assumes a simple synchronous register port from the serial interface
// decoder and ceiling codes delivered by the one-time-programmable loader.
//
// Notes on behaviour
// - Second rail mode 00 follows the active setting's mode bit, 10 forces PWM, 01 and 11 select automatic.
// - Phase register bit 4 enables current-dependent phase dropping for the second rail in PWM.
// - Phase register bit 3 enables current-dependent phase dropping for the first rail in PWM.
// - Phase register bit 2 gives the second rail one phase when 0 and two phases when 1.
// - Phase register bits 1:0 give the first rail one, two, three (0/90/180 spaced) or four phases; with DUAL_RAIL set the code clamps codes above 01 to two.
// - The first rail ceiling is a read-only 7-bit field loaded from OTP and readable only in test mode.
// - The second rail ceiling is a read-only 7-bit field loaded from OTP and readable only in test mode.
// - Voltage codes are linear from 0.30 V in 10 mV steps up to 1.57 V.
// - Bit 7 of the first setting picks PWM (0) or automatic (1) while that setting is active.
// - Bit 7 of the second setting picks PWM (0) or automatic (1) while that setting is active.
`timescale 1ns/1ps
`default_nettype none
`include "bpvcr_consts.svh"

module bpvcr_top #(
  parameter bit DUAL_RAIL = 1'b1
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       TEST_MODE,
  input  wire logic       OTP_LOAD,
  input  wire logic [6:0] OTP_A_CEILING,
  input  wire logic [6:0] OTP_B_CEILING,
  input  wire logic       SETTING_SEL_A,
  input  wire logic       SETTING_SEL_B,
  input  wire logic [1:0] RAIL_B_OPERATING_MODE,
  input  wire logic       RAIL_B_SETTING_AUTO,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  output logic            RAIL_A_SHEDDING_ENABLE,
  output logic            RAIL_B_SHEDDING_ENABLE,
  output logic      [1:0] RAIL_A_PHASES,
  output logic            RAIL_B_PHASES,
  output logic            RAIL_A_AUTO,
  output logic            RAIL_B_AUTO,
  output logic      [6:0] RAIL_A_TARGET_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  logic [7:0] phase_q;
  logic [7:0] first_q;
  logic [7:0] second_q;
  logic       we_phase;
  logic       we_first;
  logic       we_second;

  assign we_phase  = REG_WE && (REG_ADDR == `BPVCR_OFF_PHASE);
  assign we_first  = REG_WE && (REG_ADDR == `BPVCR_OFF_A_FIRST);
  assign we_second = REG_WE && (REG_ADDR == `BPVCR_OFF_A_SECOND);

  // Reserved bits 7:5 are kept writable storage as the map marks them R/W.
  bpvcr_reg8 #(
    .RESET_VAL (`BPVCR_RST_PHASE),
    .WMASK     (8'hFF)
  ) u_phase (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .we    (we_phase),
    .wdata (REG_WDATA),
    .q     (phase_q)
  );

  bpvcr_reg8 #(
    .RESET_VAL (`BPVCR_RST_TARGET),
    .WMASK     (8'hFF)
  ) u_first (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .we    (we_first),
    .wdata (REG_WDATA),
    .q     (first_q)
  );

  bpvcr_reg8 #(
    .RESET_VAL (`BPVCR_RST_TARGET),
    .WMASK     (8'hFF)
  ) u_second (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .we    (we_second),
    .wdata (REG_WDATA),
    .q     (second_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ceilings: loaded only by the OTP loader, never by software.
  bpvcr_pkg::bpvcr_vcode_t a_ceiling_q;
  bpvcr_pkg::bpvcr_vcode_t b_ceiling_q;
  logic                    a_res_q;
  logic                    b_res_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      a_ceiling_q <= 7'h7F;
      b_ceiling_q <= 7'h7F;
    end else if (CE && OTP_LOAD) begin
      a_ceiling_q <= OTP_A_CEILING;
      b_ceiling_q <= OTP_B_CEILING;
    end
  end

  // Bit 7 of the ceiling registers is a reserved R/W bit.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      a_res_q <= 1'b0;
      b_res_q <= 1'b0;
    end else if (CE && REG_WE) begin
      if (REG_ADDR == `BPVCR_OFF_A_LIMIT) begin
        a_res_q <= REG_WDATA[7];
      end
      if (REG_ADDR == `BPVCR_OFF_B_LIMIT) begin
        b_res_q <= REG_WDATA[7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the read strobe.
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    case (REG_ADDR)
      `BPVCR_OFF_PHASE:    rdata_d = phase_q;
      // Ceilings read as zero outside test mode.
      `BPVCR_OFF_A_LIMIT:  rdata_d = {a_res_q, TEST_MODE ? a_ceiling_q : 7'h00};
      `BPVCR_OFF_B_LIMIT:  rdata_d = {b_res_q, TEST_MODE ? b_ceiling_q : 7'h00};
      `BPVCR_OFF_A_FIRST:  rdata_d = first_q;
      `BPVCR_OFF_A_SECOND: rdata_d = second_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else if (CE) begin
      REG_RVALID <= REG_RE;
      if (REG_RE) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase control.
  logic [1:0] a_phase_sel;

  // Dual-rail parts clamp codes above 01 to two phases.
  // The clamp sits ahead of the output flop, so software still reads back the code it wrote.
  assign a_phase_sel = (DUAL_RAIL && (phase_q[1:0] > `BPVCR_PH_MAX_DUAL)) ?
                       `BPVCR_PH_MAX_DUAL : phase_q[1:0];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAIL_A_SHEDDING_ENABLE <= 1'b0;
      RAIL_B_SHEDDING_ENABLE <= 1'b0;
      RAIL_A_PHASES          <= 2'h0;
      RAIL_B_PHASES          <= 1'b0;
    end else if (CE) begin
      RAIL_B_SHEDDING_ENABLE <= phase_q[`BPVCR_BIT_SHED_B];
      RAIL_A_SHEDDING_ENABLE <= phase_q[`BPVCR_BIT_SHED_A];
      RAIL_B_PHASES          <= phase_q[`BPVCR_BIT_PH_B];
      RAIL_A_PHASES          <= a_phase_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and target selection.
  logic                    a_setting_auto;
  logic                    b_auto_d;
  bpvcr_pkg::bpvcr_vcode_t a_req;
  bpvcr_pkg::bpvcr_vcode_t a_code_d;

  // Codes are linear, so a numeric compare orders voltages.
  // A ceiling loaded in the same cycle only limits the target from the next cycle on.
  assign a_setting_auto = SETTING_SEL_A ? second_q[`BPVCR_BIT_AUTO] : first_q[`BPVCR_BIT_AUTO];
  assign a_req          = SETTING_SEL_A ? second_q[6:0] : first_q[6:0];
  assign a_code_d       = (a_req > a_ceiling_q) ? a_ceiling_q : a_req;

  always_comb begin
    case (RAIL_B_OPERATING_MODE)
      `BPVCR_RST_MODE: b_auto_d = RAIL_B_SETTING_AUTO;
      `BPVCR_MODE_PWM: b_auto_d = 1'b0;
      default:         b_auto_d = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAIL_A_AUTO        <= 1'b0;
      RAIL_B_AUTO        <= 1'b0;
      RAIL_A_TARGET_CODE <= 7'h00;
    end else if (CE) begin
      RAIL_A_AUTO        <= a_setting_auto;
      RAIL_B_AUTO        <= b_auto_d;
      RAIL_A_TARGET_CODE <= a_code_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Follow checks wait two edges: the register takes the write, then the output flop copies it.
  a_phase_clamp: assert property (@(posedge CLK) disable iff (RST)
    CE |=> (!DUAL_RAIL || RAIL_A_PHASES <= 2'h1))
    else $error("first rail phase count above two on dual part");

  a_target_ceiling: assert property (@(posedge CLK) disable iff (RST)
    CE && !OTP_LOAD |=> RAIL_A_TARGET_CODE <= a_ceiling_q)
    else $error("target exceeds ceiling");

  a_b_pwm_force: assert property (@(posedge CLK) disable iff (RST)
    CE && RAIL_B_OPERATING_MODE == 2'h2 |=> !RAIL_B_AUTO)
    else $error("second rail not forced to PWM");

  a_b_auto_mode: assert property (@(posedge CLK) disable iff (RST)
    CE && RAIL_B_OPERATING_MODE[0] |=> RAIL_B_AUTO)
    else $error("second rail not automatic");

  a_shed_b_follow: assert property (@(posedge CLK) disable iff (RST)
    CE && we_phase ##1 CE |=> RAIL_B_SHEDDING_ENABLE == $past(REG_WDATA[4], 2))
    else $error("second rail shedding mismatch");

  a_shed_a_follow: assert property (@(posedge CLK) disable iff (RST)
    CE && we_phase ##1 CE |=> RAIL_A_SHEDDING_ENABLE == $past(REG_WDATA[3], 2))
    else $error("first rail shedding mismatch");

  a_ph_b_follow: assert property (@(posedge CLK) disable iff (RST)
    CE && we_phase ##1 CE |=> RAIL_B_PHASES == $past(REG_WDATA[2], 2))
    else $error("second rail phase mismatch");

  a_ceiling_hidden: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_RE && !TEST_MODE && REG_ADDR == 8'hD5 |=> REG_RDATA[6:0] == 7'h00)
    else $error("ceiling visible outside test mode");

  a_ceiling_b_read: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_RE && TEST_MODE && REG_ADDR == 8'hD6 && !OTP_LOAD |=> REG_RDATA[6:0] == b_ceiling_q)
    else $error("second ceiling read wrong");

  a_a_mode_sel: assert property (@(posedge CLK) disable iff (RST)
    CE && !SETTING_SEL_A |=> RAIL_A_AUTO == $past(first_q[7]))
    else $error("first setting mode bit not applied");

  a_a_mode_sel_b: assert property (@(posedge CLK) disable iff (RST)
    CE && SETTING_SEL_A |=> RAIL_A_AUTO == $past(second_q[7]))
    else $error("second setting mode bit not applied");

  a_ph_a_follow: assert property (@(posedge CLK) disable iff (RST)
    CE && we_phase && (!DUAL_RAIL || REG_WDATA[1:0] <= 2'h1) ##1 CE |=> RAIL_A_PHASES == $past(REG_WDATA[1:0], 2))
    else $error("first rail phase count mismatch");

  a_b_follow_setting: assert property (@(posedge CLK) disable iff (RST)
    CE && RAIL_B_OPERATING_MODE == 2'h0 |=> RAIL_B_AUTO == $past(RAIL_B_SETTING_AUTO))
    else $error("second rail does not follow its setting bit");

  a_target_pass: assert property (@(posedge CLK) disable iff (RST)
    CE && a_req <= a_ceiling_q |=> RAIL_A_TARGET_CODE == $past(a_req))
    else $error("target below ceiling not applied");

  a_limit_refused: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_WE && REG_ADDR == `BPVCR_OFF_A_LIMIT && !OTP_LOAD |=> $stable(a_ceiling_q))
    else $error("first ceiling changed by software");

  a_ceiling_a_read: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_RE && TEST_MODE && REG_ADDR == `BPVCR_OFF_A_LIMIT && !OTP_LOAD |=> REG_RDATA[6:0] == a_ceiling_q)
    else $error("first ceiling read wrong");

  a_rvalid_pulse: assert property (@(posedge CLK) disable iff (RST)
    CE && REG_RE |=> REG_RVALID)
    else $error("read answer missing");

  a_rvalid_idle: assert property (@(posedge CLK) disable iff (RST)
    CE && !REG_RE |=> !REG_RVALID)
    else $error("read answer without request");

  a_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
    CE && !REG_RE |=> $stable(REG_RDATA))
    else $error("read data changed without read");

  a_ce_freeze_read: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(REG_RDATA) && $stable(REG_RVALID))
    else $error("read port moved while frozen");

  a_ce_freeze_ctrl: assert property (@(posedge CLK) disable iff (RST)
    !CE |=> $stable(RAIL_A_TARGET_CODE) && $stable(RAIL_A_AUTO) && $stable(RAIL_B_AUTO) && $stable(RAIL_A_PHASES))
    else $error("control outputs moved while frozen");

endmodule

`default_nettype wire

// ### bpvcr_top_bench.sv
// Self-checking bench for the rail configuration slice.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bpvcr_top_bench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       test_mode = 1'b0;
  logic       otp_load = 1'b0;
  logic [6:0] otp_a = 7'h00;
  logic [6:0] otp_b = 7'h00;
  logic       sel_a = 1'b0;
  logic [1:0] b_mode = 2'h0;
  logic       b_auto_bit = 1'b0;
  logic [7:0] rdata;
  logic       rvalid;
  logic       shed_a;
  logic       shed_b;
  logic [1:0] ph_a;
  logic       ph_b;
  logic       auto_a;
  logic       auto_b;
  logic [6:0] tgt_a;
  int         failures = 0;
  int         comparisons = 0;
  int         cycles = 0;

  bpvcr_top u_dut (.CLK(clk), .RST(rst), .CE(ce), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr),
    .REG_WDATA(wdata), .TEST_MODE(test_mode), .OTP_LOAD(otp_load), .OTP_A_CEILING(otp_a),
    .OTP_B_CEILING(otp_b), .SETTING_SEL_A(sel_a), .SETTING_SEL_B(1'b0), .RAIL_B_OPERATING_MODE(b_mode),
    .RAIL_B_SETTING_AUTO(b_auto_bit), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .RAIL_A_SHEDDING_ENABLE(shed_a), .RAIL_B_SHEDDING_ENABLE(shed_b), .RAIL_A_PHASES(ph_a),
    .RAIL_B_PHASES(ph_b), .RAIL_A_AUTO(auto_a), .RAIL_B_AUTO(auto_b), .RAIL_A_TARGET_CODE(tgt_a));

  always #12.5 clk = ~clk;

  // A hang is cut short well beyond the about 117 cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // The answer stands for exactly the one cycle after the read edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic seen;
    @(negedge clk);
    re = 1'b1;
    addr = a;
    @(negedge clk);
    re = 1'b0;
    seen = rvalid;
    @(negedge clk);
    chk("read valid", 8'h01, 8'(seen));
    chk("read valid end", 8'h00, 8'(rvalid));
    chk("read data", exp, rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_reads();
    rd(`BPVCR_OFF_PHASE, 8'h00);
    rd(`BPVCR_OFF_A_FIRST, 8'h00);
    rd(8'h10, 8'h00);
    rd(`BPVCR_OFF_A_LIMIT, 8'h00);
  endtask

  task automatic t_phase();
    wr(`BPVCR_OFF_PHASE, 8'h1F);
    rd(`BPVCR_OFF_PHASE, 8'h1F);
    chk("shed b", 8'h01, 8'(shed_b));
    chk("shed a", 8'h01, 8'(shed_a));
    chk("phases b", 8'h01, 8'(ph_b));
    chk("phases a clamp", 8'h01, 8'(ph_a));
    wr(`BPVCR_OFF_PHASE, 8'h00);
    chk("shed b off", 8'h00, 8'(shed_b));
    chk("shed a off", 8'h00, 8'(shed_a));
    chk("phases b one", 8'h00, 8'(ph_b));
    chk("phases a one", 8'h00, 8'(ph_a));
    wr(`BPVCR_OFF_PHASE, 8'h01);
    chk("phases a two", 8'h01, 8'(ph_a));
  endtask

  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    wr(`BPVCR_OFF_PHASE, 8'h1C);
    chk("frozen shed b", 8'h00, 8'(shed_b));
    chk("frozen phases a", 8'h01, 8'(ph_a));
    @(negedge clk);
    ce = 1'b1;
    rd(`BPVCR_OFF_PHASE, 8'h01);
  endtask

  task automatic t_reset_mid();
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("reset target", 8'h00, 8'(tgt_a));
    chk("reset phases a", 8'h00, 8'(ph_a));
    test_mode = 1'b1;
    rd(`BPVCR_OFF_A_LIMIT, 8'h7F);
    test_mode = 1'b0;
    rd(`BPVCR_OFF_A_FIRST, 8'h00);
  endtask

  task automatic t_ceilings();
    @(negedge clk);
    otp_a = 7'h46;
    otp_b = 7'h3C;
    otp_load = 1'b1;
    @(negedge clk);
    otp_load = 1'b0;
    test_mode = 1'b1;
    rd(`BPVCR_OFF_A_LIMIT, 8'h46);
    rd(`BPVCR_OFF_B_LIMIT, 8'h3C);
    wr(`BPVCR_OFF_A_LIMIT, 8'hFF);
    rd(`BPVCR_OFF_A_LIMIT, 8'hC6);
    test_mode = 1'b0;
    rd(`BPVCR_OFF_B_LIMIT, 8'h00);
  endtask

  task automatic t_targets();
    wr(`BPVCR_OFF_A_FIRST, 8'hD0);
    wr(`BPVCR_OFF_A_SECOND, 8'h20);
    chk("target clamp", 8'h46, 8'(tgt_a));
    chk("first auto", 8'h01, 8'(auto_a));
    @(negedge clk);
    sel_a = 1'b1;
    repeat (2) @(negedge clk);
    chk("second target", 8'h20, 8'(tgt_a));
    chk("second pwm", 8'h00, 8'(auto_a));
    rd(`BPVCR_OFF_A_SECOND, 8'h20);
  endtask

  task automatic t_rail_b_mode();
    logic exp;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        @(negedge clk);
        b_mode = 2'(m);
        b_auto_bit = 1'(s);
        repeat (2) @(negedge clk);
        exp = (m == 2) ? 1'b0 : ((m == 0) ? 1'(s) : 1'b1);
        chk("rail b auto", 8'(exp), 8'(auto_b));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset_reads();
    t_phase();
    t_ceilings();
    t_targets();
    t_rail_b_mode();
    t_freeze();
    t_reset_mid();
    results();
  end
endmodule

`default_nettype wire
